// ---- src/fmc_regs.vh ----
// Address map, register offsets, field positions and reset values of the flash map controller.
`ifndef FMC_REGS_VH
`define FMC_REGS_VH
`define FMC_VEC_LO 16'hFFC0
`define FMC_CODE_LO_512 16'hFE00
`define FMC_CODE_LO_1K 16'hFC00
`define FMC_CODE_LO_2K 16'hF800
`define FMC_INFO_LO 16'h1000
`define FMC_INFO_HI 16'h10FF
`define FMC_RAM_LO 16'h0200
`define FMC_RAM_HI 16'h027F
`define FMC_WPER_LO 16'h0100
`define FMC_WPER_HI 16'h01FF
`define FMC_BPER_LO 16'h0010
`define FMC_BPER_HI 16'h00FF
`define FMC_SFR_HI 16'h000F
`define FMC_CTL1_ADDR 16'h0128
`define FMC_CTL2_ADDR 16'h012A
`define FMC_CTL3_ADDR 16'h012C
`define FMC_NMI_VECTOR 16'hFFFC
`define FMC_SEG_A_BASE 16'h10C0
`define FMC_INFO_SEG_MSB 5
`define FMC_MAIN_SEG_MSB 8
`define FMC_KEY_HI 15
`define FMC_KEY_LO 8
`define FMC_KEY 8'hA5
`define FMC_KEY_READ 8'h96
`define FMC_C1_WRT 6
`define FMC_C1_MERAS 2
`define FMC_C1_ERASE 1
`define FMC_C3_VIOL 2
`define FMC_C3_LOCKA 4
`define FMC_C3_LOCK 3
`define FMC_C3_BUSY 0
`define FMC_C3_KEYV 5
`define FMC_CTL1_RST 16'h0000
`define FMC_CTL2_RST 16'h0042
`define FMC_CTL3_RST 16'h0018
`define FMC_SIZE_512 2'h0
`define FMC_SIZE_1K 2'h1
`define FMC_SIZE_2K 2'h2
`endif

// ---- src/fmc_flash_map_ctrl.v ----
// Flash memory map decoder and flash program/erase controller.
// Contract
// - Decode vectors, code, info, RAM, peripherals, SFRs.
// - Programming from CPU or debug programmer.
// - Byte and word program per write.
// - Four 64-byte information segments A to D.
// - Main flash erase segments are 512 bytes.
// - Mass erase or single main segment erase.
// - Info segments erase alone or with mass.
// - Segment A locked after reset until unlocked.
// - Three control registers at 0128h, 012Ah, 012Ch.
// - Violation flag raises NMI, gated by own enable.
// - Fetch from peripherals or unused space resets.
`timescale 1ns/1ps
`default_nettype none
`include "fmc_regs.vh"
module fmc_flash_map_ctrl (
    // Clock and reset.
    input wire core_clk_in,
    input wire nrst_in,
    // Part size strap: 0 for 512B, 1 for 1kB, 2 for 2kB of main flash.
    input wire [1:0] size_sel_in,
    // CPU bus.
    input wire [15:0] cpu_addr_in,
    input wire [15:0] cpu_wdata_in,
    input wire cpu_wr_in,
    input wire cpu_byte_in,
    input wire cpu_fetch_in,
    input wire access_violation_irq_enable_in,
    // Debug programmer port.
    input wire dbg_sel_in,
    input wire [15:0] dbg_addr_in,
    input wire [15:0] dbg_wdata_in,
    input wire dbg_wr_in,
    input wire dbg_byte_in,
    // Flash array command port; a done pulse ends each operation.
    input wire flash_done_in,
    // Region decode of the CPU address.
    output reg [6:0] region_out,
    // Register read data.
    output reg [15:0] cpu_rdata_out,
    // Flash array commands.
    output reg flash_prog_out,
    output reg flash_byte_out,
    output reg flash_seg_erase_out,
    output reg flash_mass_erase_out,
    output reg flash_info_incl_out,
    output reg [15:0] flash_addr_out,
    output reg [15:0] flash_wdata_out,
    // Status and system requests.
    output reg flash_busy_out,
    output reg access_violation_flag_out,
    output reg nmi_req_out,
    output reg [15:0] nmi_vector_out,
    output reg fetch_reset_out
);
    ////////////////////////////////////////////////////////////////////////////
    localparam ST_IDLE = 2'b01;
    localparam ST_BUSY = 2'b10;
    reg [1:0] state_ff;
    reg [15:0] ctl1_ff;
    reg [15:0] ctl2_ff;
    reg locka_ff;
    reg lock_ff;
    reg keyv_ff;
    reg [1:0] size_s1_ff;
    reg [1:0] size_ff;
    reg done_s1_ff;
    reg done_s2_ff;
    reg [15:0] code_lo;
    reg in_vec;
    reg in_code;
    reg in_info;
    reg in_ram;
    reg in_wper;
    reg in_bper;
    reg in_sfr;
    // The array reports completion from its own timing domain, so it is synchronised.
    always @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            done_s1_ff <= 1'b0;
            done_s2_ff <= 1'b0;
        end else begin
            done_s1_ff <= flash_done_in;
            done_s2_ff <= done_s1_ff;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    always @* begin
        case (size_ff)
            `FMC_SIZE_512: code_lo = `FMC_CODE_LO_512;
            `FMC_SIZE_1K: code_lo = `FMC_CODE_LO_1K;
            default: code_lo = `FMC_CODE_LO_2K;
        endcase
        in_vec = cpu_addr_in >= `FMC_VEC_LO;
        in_code = cpu_addr_in >= code_lo;
        in_info = cpu_addr_in >= `FMC_INFO_LO && cpu_addr_in <= `FMC_INFO_HI;
        in_ram = cpu_addr_in >= `FMC_RAM_LO && cpu_addr_in <= `FMC_RAM_HI;
        in_wper = cpu_addr_in >= `FMC_WPER_LO && cpu_addr_in <= `FMC_WPER_HI;
        in_bper = cpu_addr_in >= `FMC_BPER_LO && cpu_addr_in <= `FMC_BPER_HI;
        in_sfr = cpu_addr_in <= `FMC_SFR_HI;
    end
    ////////////////////////////////////////////////////////////////////////////
    // Write source: the debug port takes the bus while selected.
    wire [15:0] w_addr = dbg_sel_in ? dbg_addr_in : cpu_addr_in;
    wire [15:0] w_data = dbg_sel_in ? dbg_wdata_in : cpu_wdata_in;
    wire w_en = dbg_sel_in ? dbg_wr_in : cpu_wr_in;
    wire w_byte = dbg_sel_in ? dbg_byte_in : cpu_byte_in;
    wire key_ok = w_data[`FMC_KEY_HI:`FMC_KEY_LO] == `FMC_KEY;
    wire reg_wr = w_en && !w_byte;
    wire wr1 = reg_wr && w_addr == `FMC_CTL1_ADDR;
    wire wr2 = reg_wr && w_addr == `FMC_CTL2_ADDR;
    wire wr3 = reg_wr && w_addr == `FMC_CTL3_ADDR;
    wire bad_key = (wr1 || wr2 || wr3) && !key_ok;
    wire w_code = w_addr >= code_lo;
    wire w_info = w_addr >= `FMC_INFO_LO && w_addr <= `FMC_INFO_HI;
    wire w_sega = w_addr >= `FMC_SEG_A_BASE && w_addr <= `FMC_INFO_HI;
    wire fl_wr = w_en && (w_code || w_info);
    wire op_erase = ctl1_ff[`FMC_C1_ERASE] || ctl1_ff[`FMC_C1_MERAS];
    wire op_prog = ctl1_ff[`FMC_C1_WRT];
    // A locked segment A, a global lock or a busy array turns the write into a violation.
    wire blocked = lock_ff || state_ff == ST_BUSY || (w_sega && locka_ff) ||
        !(op_erase || op_prog);
    wire mass = ctl1_ff[`FMC_C1_MERAS];
    wire sega_mass = mass && ctl1_ff[`FMC_C1_ERASE];
    // A group erase would wipe segment A too, so while segment A is locked it is refused whatever address starts it.
    wire start = fl_wr && !blocked && !(sega_mass && locka_ff);
    wire viol = fl_wr && !start;
    wire [15:0] seg_addr = w_info ?
        {w_addr[15:`FMC_INFO_SEG_MSB+1], {(`FMC_INFO_SEG_MSB+1){1'b0}}} :
        {w_addr[15:`FMC_MAIN_SEG_MSB+1], {(`FMC_MAIN_SEG_MSB+1){1'b0}}};
    ////////////////////////////////////////////////////////////////////////////
    always @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_ff <= ST_IDLE;
            ctl1_ff <= `FMC_CTL1_RST;
            ctl2_ff <= `FMC_CTL2_RST;
            locka_ff <= 1'b1;
            lock_ff <= 1'b1;
            keyv_ff <= 1'b0;
            size_s1_ff <= `FMC_SIZE_512;
            size_ff <= `FMC_SIZE_512;
            region_out <= 7'h00;
            cpu_rdata_out <= 16'h0000;
            flash_prog_out <= 1'b0;
            flash_byte_out <= 1'b0;
            flash_seg_erase_out <= 1'b0;
            flash_mass_erase_out <= 1'b0;
            flash_info_incl_out <= 1'b0;
            flash_addr_out <= 16'h0000;
            flash_wdata_out <= 16'h0000;
            flash_busy_out <= 1'b0;
            access_violation_flag_out <= 1'b0;
            nmi_req_out <= 1'b0;
            nmi_vector_out <= `FMC_NMI_VECTOR;
            fetch_reset_out <= 1'b0;
        end else begin
            // The strap is a pin level, so it passes two flip-flops before the decoder sees it.
            size_s1_ff <= size_sel_in;
            size_ff <= size_s1_ff;
            region_out <= {in_sfr, in_bper, in_wper, in_ram, in_info, in_code, in_vec};
            fetch_reset_out <= cpu_fetch_in &&
                !(in_vec || in_code || in_info || in_ram);
            if (wr1 && key_ok && state_ff == ST_IDLE) ctl1_ff <= {8'h00, w_data[7:0]};
            if (wr2 && key_ok && state_ff == ST_IDLE) ctl2_ff <= {8'h00, w_data[7:0]};
            if (wr3 && key_ok) begin
                lock_ff <= w_data[`FMC_C3_LOCK];
                // Writing a one toggles the segment A lock so an unlock persists until rewritten.
                if (w_data[`FMC_C3_LOCKA]) locka_ff <= !locka_ff;
            end
            if (bad_key) keyv_ff <= 1'b1;
            else if (wr3 && !w_data[`FMC_C3_KEYV]) keyv_ff <= 1'b0;
            // A new violation wins over a clear in the same cycle.
            if (viol) access_violation_flag_out <= 1'b1;
            else if (wr3 && key_ok && !w_data[`FMC_C3_VIOL]) access_violation_flag_out <= 1'b0;
            nmi_req_out <= (viol || access_violation_flag_out) &&
                access_violation_irq_enable_in;
            cpu_rdata_out <= 16'h0000;
            if (cpu_addr_in == `FMC_CTL1_ADDR) cpu_rdata_out <= {`FMC_KEY_READ, ctl1_ff[7:0]};
            if (cpu_addr_in == `FMC_CTL2_ADDR) cpu_rdata_out <= {`FMC_KEY_READ, ctl2_ff[7:0]};
            if (cpu_addr_in == `FMC_CTL3_ADDR)
                cpu_rdata_out <= {`FMC_KEY_READ, 2'b00, keyv_ff, locka_ff, lock_ff,
                    access_violation_flag_out, 1'b0, flash_busy_out};
            case (state_ff)
                ST_IDLE: begin
                    flash_prog_out <= 1'b0;
                    flash_seg_erase_out <= 1'b0;
                    flash_mass_erase_out <= 1'b0;
                    if (start) begin
                        state_ff <= ST_BUSY;
                        flash_busy_out <= 1'b1;
                        flash_prog_out <= op_prog && !op_erase;
                        flash_byte_out <= w_byte;
                        flash_mass_erase_out <= mass;
                        flash_info_incl_out <= sega_mass;
                        flash_seg_erase_out <= !mass && ctl1_ff[`FMC_C1_ERASE];
                        flash_addr_out <= op_erase ? seg_addr : w_addr;
                        flash_wdata_out <= w_data;
                    end
                end
                ST_BUSY: begin
                    if (done_s2_ff) begin
                        state_ff <= ST_IDLE;
                        flash_busy_out <= 1'b0;
                        flash_prog_out <= 1'b0;
                        flash_seg_erase_out <= 1'b0;
                        flash_mass_erase_out <= 1'b0;
                        flash_info_incl_out <= 1'b0;
                        flash_byte_out <= 1'b0;
                        // Erase modes are one-shot; programming stays armed for the next write.
                        if (op_erase) begin
                            ctl1_ff[`FMC_C1_MERAS] <= 1'b0;
                            ctl1_ff[`FMC_C1_ERASE] <= 1'b0;
                        end
                    end
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end
endmodule // fmc_flash_map_ctrl
`default_nettype wire

// ---- dv/fmc_flash_chk.sv ----
// Port-level checker for the flash map controller.
`timescale 1ns/1ps
`default_nettype none
module fmc_flash_chk (
    // Clock and reset.
    input wire logic core_clk_in,
    input wire logic nrst_in,
    // Inputs watched.
    input wire logic [15:0] cpu_addr_in,
    input wire logic cpu_fetch_in,
    input wire logic access_violation_irq_enable_in,
    input wire logic flash_done_in,
    // Outputs watched.
    input wire logic [6:0] region_out,
    input wire logic flash_prog_out,
    input wire logic flash_mass_erase_out,
    input wire logic flash_info_incl_out,
    input wire logic flash_busy_out,
    input wire logic nmi_req_out,
    input wire logic fetch_reset_out
);
    default clocking @(posedge core_clk_in);
    endclocking
    default disable iff (!nrst_in);
    a_ram_decode: assert property (
        cpu_addr_in inside {[16'h0200:16'h027F]} |=> region_out == 7'h08) else $error("ram");
    a_info_decode: assert property (
        cpu_addr_in inside {[16'h1000:16'h10FF]} |=> region_out == 7'h04) else $error("info");
    a_nmi_gated: assert property (
        !access_violation_irq_enable_in && !$past(access_violation_irq_enable_in)
        |-> !nmi_req_out) else $error("nmi ungated");
    a_fetch_reset: assert property (
        cpu_fetch_in && cpu_addr_in inside {[16'h0100:16'h01FF]} |=> fetch_reset_out)
        else $error("no fetch reset");
    a_fetch_quiet: assert property (
        !cpu_fetch_in |=> !fetch_reset_out) else $error("stray fetch reset");
    a_prog_busy: assert property (
        flash_prog_out |-> flash_busy_out) else $error("prog not busy");
    a_info_mass: assert property (
        flash_info_incl_out |-> flash_mass_erase_out) else $error("info without mass");
    a_done_release: assert property (
        $rose(flash_done_in) && flash_busy_out |-> ##[1:5] !flash_busy_out)
        else $error("busy stuck");
endmodule // fmc_flash_chk
bind fmc_flash_map_ctrl fmc_flash_chk i_chk (.core_clk_in(core_clk_in), .nrst_in(nrst_in),
    .cpu_addr_in(cpu_addr_in), .cpu_fetch_in(cpu_fetch_in), .flash_done_in(flash_done_in),
    .access_violation_irq_enable_in(access_violation_irq_enable_in), .region_out(region_out),
    .flash_prog_out(flash_prog_out), .flash_mass_erase_out(flash_mass_erase_out),
    .flash_info_incl_out(flash_info_incl_out), .flash_busy_out(flash_busy_out),
    .nmi_req_out(nmi_req_out), .fetch_reset_out(fetch_reset_out));
`default_nettype wire

// ---- dv/fmc_flash_array.sv ----
// Behavioural flash array answering each command with a done level.
`timescale 1ns/1ps
`default_nettype none
module fmc_flash_array (
    // Clock and reset.
    input wire logic core_clk_in,
    input wire logic nrst_in,
    // Pace, command and answer.
    input wire logic slow_in,
    input wire logic cmd_in,
    output var logic done_out
);
    int n;
    // Done stands four clocks so the two-flop synchroniser cannot miss it.
    always @(posedge core_clk_in or negedge nrst_in) begin
        n <= (!nrst_in || !cmd_in) ? 0 : n + 1;
        done_out <= nrst_in && cmd_in && n >= (slow_in ? 40 : 2) && n < (slow_in ? 44 : 6);
    end
endmodule // fmc_flash_array
`default_nettype wire

// ---- dv/fmc_flash_map_ctrl_bench.sv ----
// Self-checking bench for the flash map controller.
`timescale 1ns/1ps
`default_nettype none
module fmc_flash_map_ctrl_bench;
    logic clk = 0, rst_n = 0, wr = 0, byt = 0, fe = 0, ie = 0, dsel = 0, slow = 0, done;
    logic [1:0] sz = 2'h2;
    logic [15:0] a = 16'h0000, d = 16'h0000, rdat, faddr, fwd, nvec;
    logic [6:0] reg_o, e;
    logic prog, fbyte, serase, merase, incl, busy, flag, nmi, frst;
    int mismatches = 0, n_checks = 0;
    logic [15:0] bases [11] = '{16'h0008, 16'h00F8, 16'h01F8, 16'h0278, 16'h0FF8, 16'h10F8,
        16'hF7F8, 16'hFBF8, 16'hFDF8, 16'hFFB8, 16'hFFF8};
    fmc_flash_map_ctrl i_dut (.core_clk_in(clk), .nrst_in(rst_n), .size_sel_in(sz),
        .cpu_addr_in(a), .cpu_wdata_in(d), .cpu_wr_in(wr & ~dsel), .cpu_byte_in(byt),
        .cpu_fetch_in(fe), .access_violation_irq_enable_in(ie), .dbg_sel_in(dsel),
        .dbg_addr_in(a), .dbg_wdata_in(d), .dbg_wr_in(wr & dsel), .dbg_byte_in(byt),
        .flash_done_in(done), .region_out(reg_o), .cpu_rdata_out(rdat), .flash_prog_out(prog),
        .flash_byte_out(fbyte), .flash_seg_erase_out(serase), .flash_mass_erase_out(merase),
        .flash_info_incl_out(incl), .flash_addr_out(faddr), .flash_wdata_out(fwd),
        .flash_busy_out(busy), .access_violation_flag_out(flag), .nmi_req_out(nmi),
        .nmi_vector_out(nvec), .fetch_reset_out(frst));
    fmc_flash_array i_arr (.core_clk_in(clk), .nrst_in(rst_n), .slow_in(slow),
        .cmd_in(prog | serase | merase), .done_out(done));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [6:0] exp_reg(input logic [15:0] x, input logic [1:0] s);
        logic [15:0] cb;
        cb = (s == 2'h0) ? 16'hFE00 : (s == 2'h1) ? 16'hFC00 : 16'hF800;
        return {x <= 16'h000F, x >= 16'h0010 && x <= 16'h00FF, x >= 16'h0100 && x <= 16'h01FF,
            x >= 16'h0200 && x <= 16'h027F, x >= 16'h1000 && x <= 16'h10FF, x >= cb,
            x >= 16'hFFC0};
    endfunction
    task automatic chk(input logic [15:0] g, w);
        n_checks++;
        if (g !== w) begin
            mismatches++;
            $display("[ERR] %0t got %h want %h", $time, g, w);
        end
    endtask
    task automatic wr1(input logic [15:0] ad, dt, input logic b);
        @(negedge clk);
        {a, d, byt, wr} = {ad, dt, b, 1'b1};
        @(negedge clk);
        wr = 0;
    endtask
    task automatic rd(input logic [15:0] ad, w);
        @(negedge clk);
        a = ad;
        @(negedge clk);
        chk(rdat, w);
    endtask
    // A refused write is followed by a flag clear, which also drops the general lock.
    task automatic op(input logic [7:0] c, input logic [15:0] ad, input logic b, ds,
            input logic [3:0] cmd);
        logic [15:0] dt;
        dt = 16'($urandom);
        wr1(16'h0128, {8'hA5, c}, 0);
        dsel = ds;
        wr1(ad, dt, b);
        @(negedge clk);
        chk({prog, fbyte, serase, merase, incl, busy}, {cmd[3], cmd[3] & b, cmd[2:0], |cmd});
        chk({flag, nmi}, {~|cmd, ie & ~|cmd});
        // Erases address the segment base: 64-byte info or 512-byte main segments.
        if (|cmd) chk(faddr, cmd[3] ? ad : ad & (ad[15:8] == 8'h10 ? 16'hFFC0 : 16'hFE00));
        if (cmd[3]) chk(fwd, dt);
        for (int i = 0; i < 100 && busy; i++) @(negedge clk);
        chk(busy, 0);
        dsel = 0;
        if (!cmd) wr1(16'h012C, 16'hA500, 0);
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        forever #2 clk = ~clk;
    end
    initial begin
        repeat (5000) @(posedge clk);
        mismatches++;
        results();
    end
    initial begin
        e = 7'($urandom(10));
        repeat (20) @(posedge clk);
        @(negedge clk) rst_n = 1;
        rd(16'h0128, 16'h9600);
        rd(16'h012A, 16'h9642);
        rd(16'h012C, 16'h9618);
        chk(nvec, 16'hFFFC);
        // The size strap passes two flip-flops, so each size settles before addresses run.
        for (int s = 0; s < 3; s++) begin
            sz = 2'(s);
            repeat (3) @(negedge clk);
            for (int i = 0; i < 20; i++) begin
                a = bases[$urandom % 11] + 16'($urandom % 16);
                fe = 1'($urandom);
                e = exp_reg(a, sz);
                @(negedge clk);
                chk(reg_o, e);
                chk(frst, fe & ~|e[3:0]);
            end
        end
        {fe, sz} = {1'b0, 2'h2};
        op(8'h40, 16'hF900, 0, 0, 4'h0);
        ie = 1;
        op(8'h40, 16'hF902, 0, 0, 4'h8);
        op(8'h40, 16'hFFC1, 1, 0, 4'h8);
        slow = 1;
        op(8'h02, 16'hFA10, 0, 0, 4'h4);
        slow = 0;
        op(8'h04, 16'hF800, 0, 0, 4'h2);
        op(8'h06, 16'hF800, 0, 0, 4'h0);
        op(8'h02, 16'h10BF, 0, 0, 4'h4);
        op(8'h40, 16'h10C0, 0, 0, 4'h0);
        wr1(16'h012C, 16'hA510, 0);
        rd(16'h012C, 16'h9600);
        op(8'h40, 16'h10C0, 0, 0, 4'h8);
        op(8'h06, 16'hF800, 0, 0, 4'h3);
        op(8'h40, 16'hFC00, 0, 1, 4'h8);
        wr1(16'h012C, 16'hA510, 0);
        wr1(16'h0128, 16'h0040, 0);
        rd(16'h012C, 16'h9630);
        rst_n = 0;
        repeat (3) @(negedge clk);
        rst_n = 1;
        rd(16'h012C, 16'h9618);
        results();
    end
endmodule // fmc_flash_map_ctrl_bench
`default_nettype wire
